// >>> common/rpd_regs.svh
// Constants of the receive packet delivery block
// Operation
// - Default mode forwards validated, address-accepted packet bytes with no control bytes.
// - Default mode sends each packet right after the previous one, no separator.
// - With options bit 2 set, packets wait for a fetch command choosing returned bytes.
// - Status appears on clear-to-send or command response line per line select option.
// - Valid packet sets receive-waiting flag; masked flag drives exception line high.
// - An accepted fetch queues the acknowledge byte on the same edge that raises the status line.
// - Status line drops once every requested byte has been transmitted.
// - After header fetch, data fetch returns its data; other fetches discard it.
// - With nothing pending, status still rises and a zero-byte transfer completes.
// - Blocks start with tag 01, 02, 11 or 12, then a length byte (header length or data length).
// - Unencrypted header carries a hop identifier byte, zero to five, after frame type.
// - A one-byte sequence equal to the previous packet's is dropped; sender counts modulo 256.
// - Address fields are 2 bytes in user mode, 4 bytes in the other modes.
// - Unencrypted packets need a matching customer identifier, absent in serial-number mode.
// - Header data length equals the data block length byte and counts payload bytes.
// - Encrypted packets are delivered with decrypted header and data content.
// - Hop key holds hop number in low bits, key selector in bits 6 to 7.
// - Encrypted six-byte sequence; a duplicate of the previous packet is dropped.
// - Encrypted header data length counts the payload type byte; data block length is one less.
// - Payload type byte is reported in the encrypted header.
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// ============================================================
// Options and identifiers
`define RPD_OPT_EXPLICIT_BIT 2
`define RPD_COMPATIBILITY_SETTING_NEW       2'h2
`define RPD_CUST_COMPAT2     16'h7fff
`define RPD_CUST_DEFAULT     16'hffff
`define RPD_ACK_BYTE         8'h06

// ============================================================
// Block tags
`define RPD_TAG_HDR          8'h01
`define RPD_TAG_DATA         8'h02
`define RPD_TAG_EHDR         8'h11
`define RPD_TAG_EDATA        8'h12

// ============================================================
// Field sizes in bytes; header vector width in bits
`define RPD_HDR_PRE          8'h02
`define RPD_ONE_BYTE         8'h01
`define RPD_USEQ_BYTES       8'h01
`define RPD_ESEQ_BYTES       8'h06
`define RPD_CUST_BYTES       8'h02
`define RPD_ADDR_SHORT       8'h02
`define RPD_ADDR_LONG        8'h04
`define RPD_DSN_BYTES        8'h04
`define RPD_HDR_BITS         192
`define RPD_DATA_PRE         9'h002
`define RPD_STEP             9'h001

`endif

// >>> common/rpd_pkg.sv
// Types shared by the receive packet delivery block
package rpd_pkg;

    typedef enum logic [1:0] {RPD_DSN, RPD_USER, RPD_EXT} rpd_addr_mode_type;

    typedef enum logic [1:0] {RPD_FETCH_HDR, RPD_FETCH_DATA, RPD_FETCH_BOTH} rpd_fetch_type;

    typedef enum {S_IDLE, S_ACK, S_RAISE, S_FETCH, S_PUSH, S_DRAIN, S_LOWER} rpd_state_type;

    // Descriptor of a received, already decrypted packet
    typedef struct packed {
        logic              crc_ok;
        logic              addr_ok;
        logic              encrypted;
        logic              ack_req;
        logic              long_pre;
        rpd_addr_mode_type mode;
        logic [2:0]        hop;
        logic [1:0]        key_sel;
        logic [47:0]       seq;
        logic [15:0]       cust_id;
        logic [31:0]       dest;
        logic [31:0]       src;
        logic [31:0]       src_dsn;
        logic [7:0]        payload_type;
    } rpd_info_type;

endpackage : rpd_pkg

// >>> core/rpd_byte_mem.sv
// Payload store with registered read data
`timescale 1ns/1ns
module rpd_byte_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : rpd_byte_mem

// >>> core/rpd_delivery.sv
// Receive packet delivery: default stream and explicit fetch transfer cycle
`timescale 1ns/1ns
`include "rpd_regs.svh"
module rpd_delivery #(
    parameter int         DEPTH   = 256,
    parameter logic [7:0] FT_DSN  = 8'h00,
    parameter logic [7:0] FT_USER = 8'h01,
    parameter logic [7:0] FT_EXT  = 8'h02,
    parameter logic [7:0] FT_ACK  = 8'h10,
    parameter logic [7:0] FT_ENC  = 8'h20,
    parameter logic [7:0] FT_LONG = 8'h40
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // Received packet stream
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_byte,
    input  wire logic                  rx_last,
    input  wire rpd_pkg::rpd_info_type rx_info,
    output logic                       rx_ready,
    // Configuration
    input  wire logic [7:0]            packet_options_register,
    input  wire logic                  status_line_select,
    input  wire logic [1:0]            compatibility_setting,
    input  wire logic                  customer_id_set,
    input  wire logic [15:0]           customer_id_value,
    input  wire logic                  extended_exception_mask_1,
    input  wire logic                  receive_waiting_clear,
    // Fetch commands
    input  wire logic                  cmd_valid,
    input  wire rpd_pkg::rpd_fetch_type cmd_kind,
    // Host handshake lines
    input  wire logic                  command_select_line,
    output logic                       clear_to_send_line,
    output logic                       command_response_line,
    output logic                       exception_line,
    output logic                       receive_waiting_flag,
    // Serial transmit byte stream
    output logic                       tx_valid,
    output logic [7:0]                 tx_data,
    input  wire logic                  tx_ready
);

    localparam int AW = $clog2(DEPTH);

    // ============================================================
    // Header formatting

    function automatic logic [7:0] frame_type(input rpd_pkg::rpd_info_type i);
        logic [7:0] f;
        f = (i.mode == rpd_pkg::RPD_DSN) ? FT_DSN : (i.mode == rpd_pkg::RPD_USER) ? FT_USER : FT_EXT;
        if (i.ack_req) f = f | FT_ACK;
        if (i.encrypted) f = f | FT_ENC;
        if (i.long_pre) f = f | FT_LONG;
        return f;
    endfunction : frame_type

    function automatic logic [7:0] addr_bytes(input rpd_pkg::rpd_info_type i);
        return (i.mode == rpd_pkg::RPD_USER) ? `RPD_ADDR_SHORT : `RPD_ADDR_LONG;
    endfunction : addr_bytes

    function automatic logic [`RPD_HDR_BITS-1:0] put(input logic [`RPD_HDR_BITS-1:0] h,
                                                     input logic [7:0] p, input logic [47:0] v,
                                                     input logic [7:0] n);
        logic [`RPD_HDR_BITS-1:0] r;
        r = h;
        // Multi-byte fields go most significant byte first
        for (int k = 0; k < n; k++) begin
            r[8*(p+k) +: 8] = v[8*(n-1-k) +: 8];
        end
        return r;
    endfunction : put

    function automatic logic [`RPD_HDR_BITS-1:0] hdr_bytes(input rpd_pkg::rpd_info_type i,
                                                           input logic [7:0] dl);
        logic [`RPD_HDR_BITS-1:0] h;
        logic [7:0] p;
        logic [7:0] aw;
        logic [7:0] hop;
        logic [7:0] sq;
        h = '0;
        p = `RPD_HDR_PRE;
        aw = addr_bytes(i);
        hop = i.encrypted ? {i.key_sel, 3'h0, i.hop} : {5'h00, i.hop};
        sq = i.encrypted ? `RPD_ESEQ_BYTES : `RPD_USEQ_BYTES;
        h = put(h, p, 48'(frame_type(i)), `RPD_ONE_BYTE);
        p = p + `RPD_ONE_BYTE;
        h = put(h, p, 48'(hop), `RPD_ONE_BYTE);
        p = p + `RPD_ONE_BYTE;
        h = put(h, p, i.seq, sq);
        p = p + sq;
        if (!i.encrypted && i.mode != rpd_pkg::RPD_DSN) begin
            h = put(h, p, 48'(i.cust_id), `RPD_CUST_BYTES);
            p = p + `RPD_CUST_BYTES;
        end
        h = put(h, p, 48'(i.dest), aw);
        p = p + aw;
        h = put(h, p, 48'(i.src), aw);
        p = p + aw;
        if (i.mode != rpd_pkg::RPD_DSN) begin
            h = put(h, p, 48'(i.src_dsn), `RPD_DSN_BYTES);
            p = p + `RPD_DSN_BYTES;
        end
        if (i.encrypted) begin
            h = put(h, p, 48'(dl + `RPD_ONE_BYTE), `RPD_ONE_BYTE);
            p = p + `RPD_ONE_BYTE;
            h = put(h, p, 48'(i.payload_type), `RPD_ONE_BYTE);
            p = p + `RPD_ONE_BYTE;
        end else begin
            h = put(h, p, 48'(dl), `RPD_ONE_BYTE);
            p = p + `RPD_ONE_BYTE;
        end
        h[7:0] = i.encrypted ? `RPD_TAG_EHDR : `RPD_TAG_HDR;
        h[15:8] = p - `RPD_HDR_PRE;
        return h;
    endfunction : hdr_bytes

    function automatic logic [7:0] hdr_size(input rpd_pkg::rpd_info_type i);
        logic [7:0] n;
        n = `RPD_HDR_PRE + `RPD_ONE_BYTE + `RPD_ONE_BYTE + addr_bytes(i) + addr_bytes(i);
        if (i.encrypted) begin
            n = n + `RPD_ESEQ_BYTES + `RPD_ONE_BYTE + `RPD_ONE_BYTE;
        end else begin
            n = n + `RPD_USEQ_BYTES + `RPD_ONE_BYTE;
        end
        if (!i.encrypted && i.mode != rpd_pkg::RPD_DSN) n = n + `RPD_CUST_BYTES;
        if (i.mode != rpd_pkg::RPD_DSN) n = n + `RPD_DSN_BYTES;
        return n;
    endfunction : hdr_size

    // ============================================================
    // Command select synchroniser

    logic sel_meta;
    logic sel_sync;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
        end else begin
            sel_meta <= command_select_line;
            sel_sync <= sel_meta;
        end
    end

    // ============================================================
    // Packet intake and validation

    rpd_pkg::rpd_state_type state;
    rpd_pkg::rpd_state_type next_state;
    rpd_pkg::rpd_info_type  info;
    logic [AW-1:0]          wr_cnt;
    logic [7:0]             dlen;
    logic                   pending;
    logic                   seen;
    logic                   last_enc;
    logic [47:0]            last_seq;
    logic                   hdr_on;
    logic                   data_on;
    logic                   raw;
    logic                   hdr_done;
    logic                   status;
    logic [8:0]             idx;
    logic                   v1;
    logic [7:0]             b1;
    logic [7:0]             mem_q;

    wire        explicit_mode = packet_options_register[`RPD_OPT_EXPLICIT_BIT];
    wire        rx_fire       = rx_valid && rx_ready;
    wire        rx_end        = rx_fire && rx_last;
    wire [15:0] own_cust      = customer_id_set ? customer_id_value :
                                (compatibility_setting == `RPD_COMPATIBILITY_SETTING_NEW) ? `RPD_CUST_COMPAT2 : `RPD_CUST_DEFAULT;
    wire        cust_ok       = rx_info.encrypted || rx_info.mode == rpd_pkg::RPD_DSN ||
                                rx_info.cust_id == own_cust;
    wire        seq_same      = rx_info.encrypted ? (rx_info.seq == last_seq) :
                                (rx_info.seq[7:0] == last_seq[7:0]);
    wire        dup           = seen && (rx_info.encrypted == last_enc) && seq_same;
    wire        accept        = rx_end && rx_info.crc_ok && rx_info.addr_ok && cust_ok && !dup;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_cnt <= '0;
        end else if (rx_fire) begin
            wr_cnt <= rx_last ? '0 : wr_cnt + 1'b1;
        end
    end

    // Only the newest accepted packet is compared, so a late retransmission after another packet passes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            info     <= '0;
            dlen     <= 8'h00;
            seen     <= 1'b0;
            last_enc <= 1'b0;
            last_seq <= 48'h0;
        end else if (accept) begin
            info     <= rx_info;
            dlen     <= 8'(wr_cnt) + `RPD_ONE_BYTE;
            seen     <= 1'b1;
            last_enc <= rx_info.encrypted;
            last_seq <= rx_info.seq;
        end
    end

    // ============================================================
    // Transfer sequencing

    wire       idle       = state == rpd_pkg::S_IDLE;
    wire       cmd_take   = idle && explicit_mode && cmd_valid;
    wire       start_raw  = idle && !explicit_mode && pending;
    wire       discard    = cmd_take && hdr_done && cmd_kind != rpd_pkg::RPD_FETCH_DATA;
    wire       avail      = pending && !discard;
    wire       buf_empty  = !tx_valid && !v1;
    wire       done_drain = state == rpd_pkg::S_DRAIN && buf_empty;
    wire       release_pk = (done_drain && data_on) || discard;
    wire       next_pending = accept ? 1'b1 : (release_pk ? 1'b0 : pending);
    wire [7:0] hsize      = hdr_size(info);
    wire [8:0] hoff       = hdr_on ? 9'(hsize) : 9'h000;
    wire [8:0] dsize      = data_on ? (raw ? 9'h000 : `RPD_DATA_PRE) + 9'(dlen) : 9'h000;
    wire [8:0] total      = hoff + dsize;
    wire [8:0] rel        = idx - hoff;
    wire [AW-1:0] rd_addr = raw ? AW'(idx) : AW'(rel - `RPD_DATA_PRE);
    wire [`RPD_HDR_BITS-1:0] hdr_vec = hdr_bytes(info, dlen);
    wire       src_valid  = state == rpd_pkg::S_ACK || state == rpd_pkg::S_PUSH;
    wire       push       = src_valid && !v1;
    wire       last_byte  = (idx + `RPD_STEP) == total;
    wire [7:0] data_tag   = info.encrypted ? `RPD_TAG_EDATA : `RPD_TAG_DATA;
    wire [7:0] src_byte   = (state == rpd_pkg::S_ACK) ? `RPD_ACK_BYTE :
                            (idx < hoff) ? hdr_vec[8*idx +: 8] :
                            raw ? mem_q :
                            (rel == 9'h000) ? data_tag :
                            (rel == `RPD_STEP) ? dlen : mem_q;
    wire       next_status = (state == rpd_pkg::S_ACK && push) ? 1'b1 :
                             (done_drain && !raw) ? 1'b0 : status;

    rpd_byte_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_mem (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .wr_en   (rx_fire),
        .wr_addr (wr_cnt),
        .wr_data (rx_byte),
        .rd_addr (rd_addr),
        .rd_data (mem_q)
    );

    always_comb begin
        next_state = state;
        case (state)
            rpd_pkg::S_IDLE: begin
                if (cmd_take) next_state = rpd_pkg::S_ACK;
                else if (start_raw) next_state = rpd_pkg::S_FETCH;
            end
            rpd_pkg::S_ACK: begin
                if (push) next_state = rpd_pkg::S_RAISE;
            end
            rpd_pkg::S_RAISE: begin
                // Zero-byte transfers also wait here for the host
                if (sel_sync) next_state = (total == 9'h000) ? rpd_pkg::S_DRAIN : rpd_pkg::S_FETCH;
            end
            rpd_pkg::S_FETCH: begin
                next_state = rpd_pkg::S_PUSH;
            end
            rpd_pkg::S_PUSH: begin
                if (push) next_state = last_byte ? rpd_pkg::S_DRAIN : rpd_pkg::S_FETCH;
            end
            rpd_pkg::S_DRAIN: begin
                if (buf_empty) next_state = raw ? rpd_pkg::S_IDLE : rpd_pkg::S_LOWER;
            end
            rpd_pkg::S_LOWER: begin
                if (!sel_sync) next_state = rpd_pkg::S_IDLE;
            end
            default: begin
                next_state = rpd_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state   <= rpd_pkg::S_IDLE;
            pending <= 1'b0;
            status  <= 1'b0;
        end else begin
            state   <= next_state;
            pending <= next_pending;
            status  <= next_status;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hdr_on  <= 1'b0;
            data_on <= 1'b0;
            raw     <= 1'b0;
        end else if (cmd_take) begin
            hdr_on  <= avail && cmd_kind != rpd_pkg::RPD_FETCH_DATA;
            data_on <= avail && cmd_kind != rpd_pkg::RPD_FETCH_HDR;
            raw     <= 1'b0;
        end else if (start_raw) begin
            hdr_on  <= 1'b0;
            data_on <= 1'b1;
            raw     <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hdr_done <= 1'b0;
        end else if (cmd_take) begin
            hdr_done <= avail && cmd_kind == rpd_pkg::RPD_FETCH_HDR;
        end else if (release_pk) begin
            hdr_done <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idx <= 9'h000;
        end else if (start_raw || state == rpd_pkg::S_RAISE) begin
            idx <= 9'h000;
        end else if (state == rpd_pkg::S_PUSH && push) begin
            idx <= idx + `RPD_STEP;
        end
    end

    // ============================================================
    // Two-entry output buffer; a stalled transmitter loses nothing

    wire       pop          = tx_valid && tx_ready;
    wire [7:0] next_tx_data = pop ? (v1 ? b1 : src_byte) : (tx_valid ? tx_data : src_byte);
    wire       next_tx_valid = pop ? (v1 || push) : (tx_valid || push);
    wire       load_b1      = push && ((pop && v1) || (!pop && tx_valid));
    wire       next_v1      = pop ? (v1 && push) : (v1 || (tx_valid && push));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            v1       <= 1'b0;
            b1       <= 8'h00;
        end else begin
            tx_valid <= next_tx_valid;
            tx_data  <= next_tx_data;
            v1       <= next_v1;
            b1       <= load_b1 ? src_byte : b1;
        end
    end

    // ============================================================
    // Status lines and receive-waiting exception

    wire next_flag = accept ? 1'b1 : (receive_waiting_clear ? 1'b0 : receive_waiting_flag);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clear_to_send_line    <= 1'b0;
            command_response_line <= 1'b0;
            receive_waiting_flag  <= 1'b0;
            exception_line        <= 1'b0;
            rx_ready              <= 1'b0;
        end else begin
            clear_to_send_line    <= next_status && !status_line_select;
            command_response_line <= next_status && status_line_select;
            receive_waiting_flag  <= next_flag;
            exception_line        <= next_flag && extended_exception_mask_1;
            rx_ready              <= !next_pending;
        end
    end

    // ============================================================
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_ack_push;
        state == rpd_pkg::S_ACK && push;
    endsequence

    sequence s_status_up;
        ##1 status && (state == rpd_pkg::S_RAISE);
    endsequence

    chk_ack_then_status: assert property (s_ack_push |-> s_status_up)
        else $error("status did not rise after acknowledge byte");
    chk_status_cause: assert property ($rose(status) |-> $past(state == rpd_pkg::S_ACK) && $past(push))
        else $error("status rose without acknowledge byte");
    chk_bytes_gated: assert property ((state == rpd_pkg::S_PUSH && push && !raw) |-> sel_sync)
        else $error("packet byte sent before command select rose");
    chk_status_drop: assert property ($fell(status) |-> $past(buf_empty) && state == rpd_pkg::S_LOWER)
        else $error("status dropped with bytes still queued");
    chk_zero_hold: assert property ((state == rpd_pkg::S_RAISE && !sel_sync) |=> status)
        else $error("status not held while waiting for command select");
    chk_flag_set: assert property (accept |=> receive_waiting_flag)
        else $error("receive waiting flag not set");
    chk_ex_line: assert property (exception_line == ($past(extended_exception_mask_1) && receive_waiting_flag))
        else $error("exception line disagrees with flag and mask");
    chk_hold_explicit: assert property ((idle && explicit_mode && !cmd_valid) |=> idle)
        else $error("packet released without fetch command");
    chk_dup_drop: assert property ((rx_end && dup && !pending) |=> !pending)
        else $error("duplicate packet was kept");
    chk_line_select: assert property (clear_to_send_line |-> !$past(status_line_select))
        else $error("status driven on wrong line");
    chk_tag_byte: assert property ((state == rpd_pkg::S_PUSH && push && hdr_on && idx == 9'h000)
                                   |-> src_byte == (info.encrypted ? `RPD_TAG_EHDR : `RPD_TAG_HDR))
        else $error("header block tag wrong");

endmodule : rpd_delivery

// >>> verif/rpd_host_model.sv
// Host model: takes serial bytes with random stalls and answers the status line
`timescale 1ns/1ns
module rpd_host_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Handshake lines
    input  wire logic status,
    output logic      command_select_line,
    output logic      tx_ready
);
    // ============================================================
    // Random stalls on both lines, so a slow host is exercised as well as a prompt one
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            command_select_line <= 1'b0;
            tx_ready            <= 1'b0;
        end else begin
            tx_ready <= #1 ($urandom % 4) != 0;
            if (status != command_select_line && ($urandom % 3) == 0) command_select_line <= #1 status;
        end
    end
endmodule : rpd_host_model

// >>> verif/tb_rpd_delivery.sv
// Self-checking bench for the receive packet delivery block
`timescale 1ns/1ns
module tb_rpd_delivery;
    logic ref_clk, nrst, rx_valid, rx_last, rx_ready, status_line_select, customer_id_set, extended_exception_mask_1;
    logic receive_waiting_clear, cmd_valid, command_select_line, clear_to_send_line, command_response_line;
    logic exception_line, receive_waiting_flag, tx_valid, tx_ready;
    logic [7:0]             rx_byte, packet_options_register, tx_data, hop, sq, ln;
    logic [1:0]             compatibility_setting;
    logic [15:0]            customer_id_value;
    rpd_pkg::rpd_info_type  rx_info;
    rpd_pkg::rpd_fetch_type cmd_kind;
    logic [7:0]             q[$], pay[$];
    int                     failures = 0;
    int                     checks = 0;
    logic [47:0]            seq = '0;
    logic                   enc = 1'b0;
    rpd_delivery dut (.*);
    rpd_host_model host (.ref_clk, .nrst, .status(status_line_select ? command_response_line : clear_to_send_line),
                         .command_select_line, .tx_ready);
    // ============================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Bad: 0 good, 1 failed check, 2 repeats the last sequence value, 3 foreign customer id
    task automatic send(input int n, input int bad, input logic hold);
        if (bad != 2) seq++;
        rx_info = '0;
        rx_info.crc_ok = (bad != 1);
        rx_info.addr_ok = 1'b1;
        rx_info.mode = (enc || bad == 3) ? rpd_pkg::RPD_USER : rpd_pkg::RPD_DSN;
        rx_info.encrypted = enc;
        rx_info.seq = seq;
        rx_info.hop = 3'($urandom % 6);
        hop = 8'(rx_info.hop);
        sq = seq[7:0];
        ln = 8'(n);
        pay = {};
        for (int i = 0; i < n; i++) begin
            rx_valid = 1'b1;
            rx_byte = 8'($urandom);
            rx_last = (i == n - 1);
            if (bad == 0 && !hold) q.push_back(rx_byte);
            pay.push_back(rx_byte);
            do @(posedge ref_clk); while (rx_ready !== 1'b1);
            #1;
        end
        rx_valid = 1'b0;
        // One idle edge keeps a following send from reassigning rx_valid in this step
        @(posedge ref_clk);
        #1;
    endtask : send
    task automatic fetch(input rpd_pkg::rpd_fetch_type k, input logic sel);
        status_line_select = sel;
        cmd_kind = k;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #1 cmd_valid = 1'b0;
        wait (q.size() == 0 && !command_select_line && !clear_to_send_line && !command_response_line);
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : fetch
    // ============================================================
    // Clock, watchdog, output monitor
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        report_and_stop;
    end
    always @(posedge ref_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            check(tx_data, q.size() > 0 ? q.pop_front() : 8'hxx);
        end
        check(8'(status_line_select ? clear_to_send_line : command_response_line), 8'h00);
    end
    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(32'h6af8));
        {nrst, rx_valid, rx_last, rx_byte, status_line_select, customer_id_set, receive_waiting_clear, cmd_valid} = '0;
        {packet_options_register, compatibility_setting, customer_id_value} = '0;
        extended_exception_mask_1 = 1'b1;
        rx_info = '0;
        cmd_kind = rpd_pkg::RPD_FETCH_HDR;
        repeat (2) @(posedge ref_clk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        send(5, 0, 0);
        send(3, 1, 0);
        send(4, 0, 0);
        send(2, 2, 0);
        send(1, 0, 0);
        fetch(rpd_pkg::RPD_FETCH_DATA, 1'b0);
        check(8'(receive_waiting_flag), 8'h01);
        check(8'(exception_line), 8'h01);
        receive_waiting_clear = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 receive_waiting_clear = 1'b0;
        check(8'(exception_line), 8'h00);
        packet_options_register = 8'h04;
        for (int s = 0; s < 2; s++) begin
            send(6, 0, 1);
            q = {q, 8'h06, 8'h02, ln, pay};
            fetch(rpd_pkg::RPD_FETCH_DATA, s[0]);
        end
        q.push_back(8'h06);
        fetch(rpd_pkg::RPD_FETCH_BOTH, 1'b1);
        for (int s = 0; s < 2; s++) begin
            send(3, 0, 1);
            q = {q, 8'h06, 8'h01, 8'h0c, 8'h00, hop, sq, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ln};
            fetch(rpd_pkg::RPD_FETCH_HDR, s[0]);
            q = s ? {q, 8'h06} : {q, 8'h06, 8'h02, ln, pay};
            fetch(s ? rpd_pkg::RPD_FETCH_BOTH : rpd_pkg::RPD_FETCH_DATA, 1'b0);
        end
        // A user-mode packet with a foreign customer id is dropped, so the fetch finds nothing
        send(2, 3, 1);
        q.push_back(8'h06);
        fetch(rpd_pkg::RPD_FETCH_DATA, 1'b0);
        // Encrypted user-mode packet; sequence bits 39 to 8 random to exercise byte order
        enc = 1'b1;
        seq[39:8] = $urandom;
        send(4, 0, 1);
        q = {q, 8'h06, 8'h11, 8'h12, 8'h21, hop, seq[47:40], seq[39:32], seq[31:24], seq[23:16], seq[15:8], seq[7:0]};
        q = {q, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ln + 8'h01, 8'h00, 8'h12, ln, pay};
        fetch(rpd_pkg::RPD_FETCH_BOTH, 1'b1);
        report_and_stop;
    end
endmodule : tb_rpd_delivery
